// ==== common/radio_pins_consts.svh ====
// constants for the host control pin block of the radio module
`ifndef RADIO_PINS_CONSTS_SVH
`define RADIO_PINS_CONSTS_SVH

`define CLK_HZ               250000000
`define CLK_PERIOD_NS        4
`define US_NS                1000
`define US_CYCLES            (`US_NS / `CLK_PERIOD_NS)
`define HOP_TOL_US           10
`define HOP_WIDTH_MIN_US     50
`define HOP_WIDTH_MAX_US     2000
`define DUTY_PERIOD_US       20
`define DUTY_PERIOD_CYCLES   (`DUTY_PERIOD_US * `US_CYCLES)
`define ADC_PERIOD_MS        10
`define ADC_PERIOD_CYCLES    (`ADC_PERIOD_MS * 1000 * `US_CYCLES)
`define ADC_CHANNELS         3
`define MAX_TDMA_NODES       5'h10
`define RATE_INDEX_MAX       4'hb
`define SPI_RATE_MAX_BPS     80640
`define SPI_RATE_MIN_BPS     6350
`define SPI_DIV_MIN          ((`CLK_HZ + `SPI_RATE_MAX_BPS - 1) / `SPI_RATE_MAX_BPS)
`define SPI_DIV_MAX          (`CLK_HZ / `SPI_RATE_MIN_BPS)
`define CRC_POLY             24'h80_0063
`define CRC_INIT             24'hff_ffff
`define IO_LINES             6
`define WAKE_LINES           4
`define MODE_TRANSPARENT     1'b1
`define MODE_PROTOCOL        1'b0

`endif

// ==== common/radio_pins_pkg.sv ====
// types shared by the host control pin block
package radio_pins_pkg;

  typedef struct packed {
    logic [5:0] dir_out;
    logic [5:0] level;
    logic [5:0] pull_up;
    logic [3:0] wake_en;
  } io_cfg_t;

  typedef struct packed {
    logic       start;
    logic [1:0] chan;
  } adc_req_t;

  typedef struct packed {
    logic       use_spi;
    logic [3:0] uart_rate_idx;
    logic [3:0] diag_rate_idx;
    logic [15:0] spi_div;
  } port_cfg_t;

  typedef enum logic [1:0] {
    ADC_IDLE,
    ADC_WAIT
  } adc_state_t;

endpackage

// ==== rtl/radio_pins.sv ====
// host control and status pin logic of the radio module
`timescale 1ns/1ps
`include "radio_pins_consts.svh"

module radio_pins
  import radio_pins_pkg::*;
#(
  parameter int ADC_PERIOD = `ADC_PERIOD_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        sop_done,
  input  wire logic        eop_done,
  output logic             packet_activity_indicator,
  input  wire logic        sleep_in,
  output logic             sleep_active,
  output logic             power_on_reset,
  input  wire logic        hop_sync_in,
  input  wire logic [17:0] hop_dwell_us,
  output logic             hop_align,
  output logic             hop_width_err,
  output logic             hop_interval_err,
  input  wire logic        mode_pin_in,
  input  wire logic        mode_pin_driven,
  input  wire logic        sw_mode_wr,
  input  wire logic        sw_mode,
  output logic             framing_transparent,
  input  wire logic        io_cfg_wr,
  input  wire io_cfg_t     io_cfg_in,
  input  wire io_cfg_t     io_poweron_cfg,
  input  wire logic [5:0]  user_io_in,
  output logic [5:0]       user_io_out,
  output logic [5:0]       user_io_oe,
  output logic [5:0]       user_io_pull_en,
  output logic             wake_request,
  input  wire logic [7:0]  duty_value_0,
  input  wire logic [7:0]  duty_value_1,
  output logic             duty_out_0,
  output logic             duty_out_1,
  output adc_req_t         adc_req,
  input  wire logic        adc_done,
  input  wire logic [9:0]  adc_data,
  output logic [9:0]       analog_in_a,
  output logic [9:0]       analog_in_b,
  output logic [9:0]       analog_in_c,
  input  wire port_cfg_t   port_cfg,
  output logic             data_on_spi,
  output logic [17:0]      uart_bit_div,
  output logic [17:0]      diag_bit_div,
  output logic [15:0]      spi_bit_div,
  input  wire logic        tdma_mode,
  input  wire logic [4:0]  node_count_cfg,
  output logic [4:0]       node_limit,
  input  wire logic        crc_clear,
  input  wire logic        crc_byte_valid,
  input  wire logic [7:0]  crc_byte,
  output logic [23:0]      crc_value
);

  localparam logic [17:0] HOP_TOL   = 18'(`HOP_TOL_US);
  localparam logic [17:0] WIDTH_MIN = 18'(`HOP_WIDTH_MIN_US);
  localparam logic [17:0] WIDTH_MAX = 18'(`HOP_WIDTH_MAX_US);
  localparam logic [12:0] DUTY_LAST = 13'(`DUTY_PERIOD_CYCLES - 1);
  localparam logic [7:0]  US_LAST   = 8'(`US_CYCLES - 1);

  // internal reset also covers the power-on reset taken on wake
  logic rst_int;
  assign rst_int = !rstn || power_on_reset;

  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [1:0] sync3_reg;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 2'h0;
    end else begin
      sync1_reg <= {mode_pin_in, hop_sync_in, sleep_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg[1:0];
    end
  end

  logic sleep_s;
  logic hop_s;
  logic mode_s;
  logic hop_rise;
  logic hop_fall;
  assign sleep_s  = sync2_reg[0];
  assign hop_s    = sync2_reg[1];
  assign mode_s   = sync2_reg[2];
  assign hop_rise = hop_s && !sync3_reg[1];
  assign hop_fall = !hop_s && sync3_reg[1];

  // held low from reset until a start symbol
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      packet_activity_indicator <= 1'b0;
    end else if (sop_done) begin
      packet_activity_indicator <= 1'b1;
    end else if (eop_done) begin
      // fall on end symbol, any direction
      packet_activity_indicator <= 1'b0;
    end
  end

  // sleep uses rstn only so the wake edge is not lost in its own reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sleep_active   <= 1'b0;
      power_on_reset <= 1'b0;
    end else begin
      sleep_active   <= sleep_s;
      power_on_reset <= sleep_active && !sleep_s;
    end
  end

  // microsecond tick for hop timing
  logic [7:0] us_cnt_reg;
  logic       us_tick;
  assign us_tick = (us_cnt_reg == US_LAST);
  always_ff @(posedge sys_clk) begin
    if (rst_int || us_tick) begin
      us_cnt_reg <= 8'h00;
    end else begin
      us_cnt_reg <= us_cnt_reg + 8'h01;
    end
  end

  logic [17:0] hop_width_reg;
  logic [17:0] hop_gap_reg;
  logic        hop_seen_reg;
  logic [17:0] gap_lo;
  logic [17:0] gap_hi;
  assign gap_lo = (hop_dwell_us > HOP_TOL) ? hop_dwell_us - HOP_TOL : 18'h0_0000;
  assign gap_hi = hop_dwell_us + HOP_TOL;

  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      hop_width_reg    <= 18'h0_0000;
      hop_gap_reg      <= 18'h0_0000;
      hop_seen_reg     <= 1'b0;
      hop_align        <= 1'b0;
      hop_width_err    <= 1'b0;
      hop_interval_err <= 1'b0;
    end else begin
      // rising edge aligns the hop timer
      hop_align <= hop_rise && !sleep_active;
      // interval outside dwell tolerance is flagged
      hop_interval_err <= hop_rise && hop_seen_reg &&
                          (hop_gap_reg < gap_lo || hop_gap_reg > gap_hi);
      // pulse width outside 50us..2ms is flagged
      hop_width_err <= hop_fall &&
                       (hop_width_reg < WIDTH_MIN || hop_width_reg > WIDTH_MAX);
      if (hop_rise) begin
        hop_gap_reg   <= 18'h0_0000;
        hop_width_reg <= 18'h0_0000;
        hop_seen_reg  <= 1'b1;
      end else if (us_tick) begin
        if (hop_gap_reg != 18'h3_ffff) begin
          hop_gap_reg <= hop_gap_reg + 18'h0_0001;
        end
        if (hop_s && hop_width_reg != 18'h3_ffff) begin
          hop_width_reg <= hop_width_reg + 18'h0_0001;
        end
      end
    end
  end

  // software mode register, transparent after reset
  logic sw_mode_reg;
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      sw_mode_reg <= `MODE_TRANSPARENT;
    end else if (sw_mode_wr) begin
      sw_mode_reg <= sw_mode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      framing_transparent <= `MODE_TRANSPARENT;
    end else begin
      framing_transparent <= mode_pin_driven ? mode_s : sw_mode_reg;
    end
  end

  // power-on io settings are caught after reset release, not under it
  io_cfg_t io_cfg_reg;
  logic    io_loaded_reg;
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      io_cfg_reg    <= '0;
      io_loaded_reg <= 1'b0;
    end else if (!io_loaded_reg) begin
      io_cfg_reg    <= io_poweron_cfg;
      io_loaded_reg <= 1'b1;
    end else if (io_cfg_wr) begin
      io_cfg_reg <= io_cfg_in;
    end
  end

  logic [5:0] io_prev_reg;
  logic [3:0] wake_hits;
  // only the low four lines can wake
  assign wake_hits = io_cfg_reg.wake_en & ~io_cfg_reg.dir_out[3:0] &
                     (user_io_in[3:0] ^ io_prev_reg[3:0]);
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      user_io_out     <= 6'h00;
      user_io_oe      <= 6'h00;
      user_io_pull_en <= 6'h00;
      io_prev_reg     <= 6'h00;
      wake_request    <= 1'b0;
    end else begin
      user_io_out     <= io_cfg_reg.level;
      user_io_oe      <= io_cfg_reg.dir_out;
      // pull-up only on lines set as inputs
      user_io_pull_en <= io_cfg_reg.pull_up & ~io_cfg_reg.dir_out;
      io_prev_reg     <= user_io_in;
      // input change wakes a sleeping module
      wake_request    <= io_loaded_reg && sleep_active && (wake_hits != 4'h0);
    end
  end

  // 8-bit duty over a 20us period
  logic [12:0] duty_cnt_reg;
  always_ff @(posedge sys_clk) begin
    if (rst_int || duty_cnt_reg == DUTY_LAST) begin
      duty_cnt_reg <= 13'h0000;
    end else begin
      duty_cnt_reg <= duty_cnt_reg + 13'h0001;
    end
  end

  logic [20:0] thr_0;
  logic [20:0] thr_1;
  assign thr_0 = 21'(duty_value_0) * 21'(`DUTY_PERIOD_CYCLES);
  assign thr_1 = 21'(duty_value_1) * 21'(`DUTY_PERIOD_CYCLES);
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      duty_out_0 <= 1'b0;
      duty_out_1 <= 1'b0;
    end else begin
      duty_out_0 <= duty_cnt_reg < thr_0[20:8];
      duty_out_1 <= duty_cnt_reg < thr_1[20:8];
    end
  end

  // round-robin conversions, one channel per period
  adc_state_t  adc_state_reg;
  logic [31:0] adc_timer_reg;
  logic [1:0]  adc_chan_reg;
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      adc_state_reg <= ADC_IDLE;
      adc_timer_reg <= 32'h0000_0000;
      adc_chan_reg  <= 2'h0;
      adc_req       <= '0;
      analog_in_a   <= 10'h000;
      analog_in_b   <= 10'h000;
      analog_in_c   <= 10'h000;
    end else begin
      adc_req.start <= 1'b0;
      case (adc_state_reg)
        ADC_IDLE: begin
          if (adc_timer_reg >= 32'(ADC_PERIOD - 1)) begin
            adc_timer_reg <= 32'h0000_0000;
            // sleeping skips sampling to save current
            if (!sleep_active) begin
              adc_req.start <= 1'b1;
              adc_req.chan  <= adc_chan_reg;
              adc_state_reg <= ADC_WAIT;
            end
          end else begin
            adc_timer_reg <= adc_timer_reg + 32'h0000_0001;
          end
        end
        ADC_WAIT: begin
          adc_timer_reg <= adc_timer_reg + 32'h0000_0001;
          if (adc_done) begin
            case (adc_chan_reg)
              2'h0: analog_in_a <= adc_data;
              2'h1: analog_in_b <= adc_data;
              default: analog_in_c <= adc_data;
            endcase
            adc_chan_reg  <= (adc_chan_reg == 2'(`ADC_CHANNELS - 1)) ? 2'h0
                                                                    : adc_chan_reg + 2'h1;
            adc_state_reg <= ADC_IDLE;
          end
        end
        default: adc_state_reg <= ADC_IDLE;
      endcase
    end
  end

  // standard rate table, index clamped to the top rate
  function automatic logic [17:0] rate_div(input logic [3:0] idx);
    logic [31:0] bps;
    bps = 32'h0000_0000;
    case ((idx > `RATE_INDEX_MAX) ? `RATE_INDEX_MAX : idx)
      4'h0: bps = 32'd1200;
      4'h1: bps = 32'd2400;
      4'h2: bps = 32'd4800;
      4'h3: bps = 32'd9600;
      4'h4: bps = 32'd19200;
      4'h5: bps = 32'd28800;
      4'h6: bps = 32'd38400;
      4'h7: bps = 32'd57600;
      4'h8: bps = 32'd76800;
      4'h9: bps = 32'd115200;
      4'ha: bps = 32'd230400;
      default: bps = 32'd460800;
    endcase
    rate_div = 18'(32'(`CLK_HZ) / bps);
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      data_on_spi  <= 1'b0;
      uart_bit_div <= rate_div(4'h3);
      diag_bit_div <= rate_div(4'h3);
      spi_bit_div  <= 16'(`SPI_DIV_MAX);
    end else begin
      // one data port at a time, diagnostic always serial
      data_on_spi  <= port_cfg.use_spi;
      uart_bit_div <= rate_div(port_cfg.uart_rate_idx);
      diag_bit_div <= rate_div(port_cfg.diag_rate_idx);
      // spi divisor clamped to the legal rate band
      if (port_cfg.spi_div < 16'(`SPI_DIV_MIN)) begin
        spi_bit_div <= 16'(`SPI_DIV_MIN);
      end else if (port_cfg.spi_div > 16'(`SPI_DIV_MAX)) begin
        spi_bit_div <= 16'(`SPI_DIV_MAX);
      end else begin
        spi_bit_div <= port_cfg.spi_div;
      end
    end
  end

  // slot table capped at sixteen remotes in tdma mode only
  always_ff @(posedge sys_clk) begin
    if (rst_int) begin
      node_limit <= `MAX_TDMA_NODES;
    end else if (tdma_mode && node_count_cfg > `MAX_TDMA_NODES) begin
      node_limit <= `MAX_TDMA_NODES;
    end else begin
      node_limit <= node_count_cfg;
    end
  end

  function automatic logic [23:0] crc_step(input logic [23:0] c, input logic [7:0] d);
    logic [23:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[23] ^ d[i]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    crc_step = r;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst_int || crc_clear) begin
      crc_value <= `CRC_INIT;
    end else if (crc_byte_valid) begin
      crc_value <= crc_step(crc_value, crc_byte);
    end
  end

endmodule

// ==== verification/radio_pins_chk.sv ====
// port assertions for the host control pin block
`timescale 1ns/1ps
module radio_pins_chk (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       sop_done,
  input wire logic       eop_done,
  input wire logic       packet_activity_indicator,
  input wire logic       sleep_in,
  input wire logic       sleep_active,
  input wire logic       power_on_reset,
  input wire logic       hop_sync_in,
  input wire logic       hop_align,
  input wire logic       mode_pin_in,
  input wire logic       mode_pin_driven,
  input wire logic       framing_transparent,
  input wire logic       tdma_mode,
  input wire logic [4:0] node_limit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_ind_rise: assert property (sop_done |=> packet_activity_indicator)
    else $error("indicator not raised");
  a_ind_fall: assert property (eop_done && !sop_done |=> !packet_activity_indicator)
    else $error("indicator not lowered");
  a_ind_reset: assert property (!$past(rstn) |-> !packet_activity_indicator)
    else $error("indicator high after reset");
  a_ind_hold: assert property (!sop_done && !packet_activity_indicator
    |=> !packet_activity_indicator)
    else $error("indicator rose without start");
  a_sleep_in: assert property (sleep_in [*4] |-> sleep_active)
    else $error("sleep not entered");
  a_por_wake: assert property ($fell(sleep_active) |-> power_on_reset)
    else $error("no reset on wake");
  a_por_only: assert property (power_on_reset |-> $fell(sleep_active))
    else $error("stray power-on reset");
  a_hop_align: assert property ($rose(hop_sync_in) && !sleep_in && !sleep_active
    |-> ##3 hop_align)
    else $error("hop edge not aligned");
  a_mode_lo: assert property ((mode_pin_driven && !mode_pin_in) [*4]
    |-> !framing_transparent)
    else $error("pin low not protocol");
  a_mode_hi: assert property ((mode_pin_driven && mode_pin_in) [*4]
    |-> framing_transparent)
    else $error("pin high not transparent");
  a_node_cap: assert property (tdma_mode [*2] |-> node_limit <= 5'h10)
    else $error("node limit above cap");
endmodule

// ==== verification/host_model.sv ====
// host and analog front-end model facing the pin block
`timescale 1ns/1ps
module host_model
  import radio_pins_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire adc_req_t adc_req,
  output logic          adc_done,
  output logic [9:0]    adc_data,
  input  wire logic     hop_go,
  input  wire logic [31:0] hop_w,
  output logic          hop_sync_in
);
  int         adc_wait = 0;
  int         hop_cnt  = 0;
  logic [1:0] chan     = 2'h0;
  initial begin
    adc_done    = 1'b0;
    adc_data    = 10'h0;
    hop_sync_in = 1'b0;
  end
  // later channels answer slowly; data is scrambled once done drops
  always @(posedge sys_clk) begin
    adc_done <= 1'b0;
    if (adc_done)
      adc_data <= ~adc_data;
    if (adc_req.start) begin
      chan     <= adc_req.chan;
      adc_wait <= 1 + 3 * adc_req.chan;
    end else if (adc_wait > 0) begin
      adc_wait <= adc_wait - 1;
      if (adc_wait == 1) begin
        adc_done <= 1'b1;
        adc_data <= {8'h40, chan};
      end
    end
  end
  always @(posedge sys_clk) begin
    if (hop_go) begin
      hop_sync_in <= 1'b1;
      hop_cnt     <= hop_w;
    end else if (hop_cnt > 1)
      hop_cnt <= hop_cnt - 1;
    else
      hop_sync_in <= 1'b0;
  end
endmodule

// ==== verification/tb_radio_pins.sv ====
// self-checking bench for the host control pin block
`timescale 1ns/1ps
module tb_radio_pins
  import radio_pins_pkg::*;
;
  // sleep input low except in sleep test
  logic sys_clk = 0, rstn = 0, sop_done = 0, eop_done = 0, sleep_in = 0;
  logic mode_pin_in = 0, mode_pin_driven = 0, sw_mode_wr = 0, sw_mode = 0;
  logic io_cfg_wr = 0, tdma_mode = 0, crc_clear = 0, crc_byte_valid = 0, hop_go = 0;
  logic packet_activity_indicator, sleep_active, power_on_reset, hop_sync_in;
  logic hop_align, hop_width_err, hop_interval_err, framing_transparent;
  logic wake_request, duty_out_0, duty_out_1, adc_done, data_on_spi;
  logic [17:0] hop_dwell_us = 18'h64, uart_bit_div, diag_bit_div;
  io_cfg_t     io_cfg_in = '0, io_poweron_cfg = '{6'h0f, 6'h05, 6'h30, 4'h0};
  logic [5:0]  user_io_in = 6'h0, user_io_out, user_io_oe, user_io_pull_en;
  logic [7:0]  duty_value_0 = 8'h80, duty_value_1 = 8'hff, crc_byte = 8'h0;
  adc_req_t    adc_req;
  logic [9:0]  adc_data, analog_in_a, analog_in_b, analog_in_c;
  port_cfg_t   port_cfg = '{1'b1, 4'h0, 4'hb, 16'h0};
  logic [15:0] spi_bit_div;
  logic [4:0]  node_count_cfg = 5'h1f, node_limit;
  logic [23:0] crc_value, exp_crc;
  logic [7:0]  bts [3] = '{8'ha5, 8'h00, 8'hff};
  int num_errors = 0, cmp_count = 0, cycles = 0, hop_w = 15000, hi0, hi1;
  int n_werr = 0, n_ierr = 0, n_wake = 0, n_por = 0, n_align = 0;

  radio_pins #(.ADC_PERIOD(50)) radio_pins_inst (.*);
  host_model host_model_inst (.sys_clk, .adc_req, .adc_done, .adc_data, .hop_go,
    .hop_w, .hop_sync_in);

  always #2 sys_clk = ~sys_clk;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // msb first, shift-left form of the packet check code
  function automatic logic [23:0] crc_next(input logic [23:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[22:0], 1'b0} ^ ((c[23] ^ b[i]) ? 24'h80_0063 : 24'h0);
    return c;
  endfunction

  always @(posedge sys_clk) begin
    cycles++;
    if (rstn) begin
      if (hop_width_err) n_werr++;
      if (hop_interval_err) n_ierr++;
      if (wake_request) n_wake++;
      if (power_on_reset) n_por++;
      if (hop_align) n_align++;
    end
    if (cycles == 80000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    cyc(5);
    check(framing_transparent, 1'b1);
    check(packet_activity_indicator, 1'b0);
    check(crc_value, 24'hff_ffff);
    cyc(1);
    rstn = 1'b1;
    cyc(3);
    check({user_io_oe, user_io_out}, {6'h0f, 6'h05});
    check(data_on_spi, 1'b1);
    check({uart_bit_div, 6'h0}, {18'h3_2dcd, 6'h0});
    check({diag_bit_div, spi_bit_div}, {18'h21e, 16'h0c1d});
    $display("test power-on done");
    sop_done = 1'b1;
    cyc(1);
    sop_done = 1'b0;
    check(packet_activity_indicator, 1'b1);
    cyc(3);
    eop_done = 1'b1;
    cyc(1);
    eop_done = 1'b0;
    check(packet_activity_indicator, 1'b0);
    sw_mode_wr = 1'b1;
    cyc(1);
    sw_mode_wr = 1'b0;
    cyc(3);
    check(framing_transparent, 1'b0);
    mode_pin_driven = 1'b1;
    mode_pin_in = 1'b1;
    cyc(5);
    check(framing_transparent, 1'b1);
    mode_pin_in = 1'b0;
    cyc(5);
    check(framing_transparent, 1'b0);
    mode_pin_in = 1'b1;
    mode_pin_driven = 1'b0;
    cyc(5);
    check(framing_transparent, 1'b0);
    $display("test packet and mode done");
    io_cfg_in = '{6'h00, 6'h00, 6'h0f, 4'hf};
    io_cfg_wr = 1'b1;
    cyc(1);
    io_cfg_wr = 1'b0;
    cyc(2);
    check({user_io_oe, user_io_pull_en}, {6'h00, 6'h0f});
    sleep_in = 1'b1;
    cyc(4);
    check(sleep_active, 1'b1);
    user_io_in = 6'h10;
    cyc(5);
    check(n_wake, 0);
    user_io_in = 6'h11;
    cyc(5);
    check(n_wake, 1);
    sleep_in = 1'b0;
    cyc(6);
    check(n_por, 1);
    check({framing_transparent, user_io_oe}, {1'b1, 6'h0f});
    $display("test io and sleep done");
    tdma_mode = 1'b1;
    cyc(3);
    check(node_limit, 5'h10);
    tdma_mode = 1'b0;
    port_cfg.spi_div = 16'hffff;
    cyc(3);
    check({node_limit, spi_bit_div}, {5'h1f, 16'h99ca});
    crc_clear = 1'b1;
    cyc(1);
    crc_clear = 1'b0;
    exp_crc = 24'hff_ffff;
    crc_byte_valid = 1'b1;
    for (int i = 0; i < 3; i++) begin
      crc_byte = bts[i];
      exp_crc = crc_next(exp_crc, bts[i]);
      cyc(1);
      check(crc_value, exp_crc);
    end
    crc_byte_valid = 1'b0;
    $display("test limits and check code done");
    hop_go = 1'b1;
    cyc(1);
    hop_go = 1'b0;
    cyc(10);
    check(n_align, 1);
    cyc(24989);
    hop_w = 2500;
    hop_go = 1'b1;
    cyc(1);
    hop_go = 1'b0;
    cyc(3000);
    check({n_align[7:0], n_ierr[7:0], n_werr[7:0]}, 24'h02_0001);
    // early third pulse breaks the dwell spacing
    hop_w = 15000;
    hop_go = 1'b1;
    cyc(1);
    hop_go = 1'b0;
    cyc(16000);
    check({n_align[7:0], n_ierr[7:0], n_werr[7:0]}, 24'h03_0101);
    $display("test hop sync done");
    cyc(5000);
    hi0 = 0;
    hi1 = 0;
    repeat (5000) begin
      cyc(1);
      hi0 += int'(duty_out_0);
      hi1 += int'(duty_out_1);
    end
    check(hi0, (8'h80 * 5000) >> 8);
    check(hi1, (8'hff * 5000) >> 8);
    check({analog_in_a, analog_in_b}, {10'h100, 10'h101});
    check(analog_in_c, 10'h102);
    $display("test duty and analog done");
    conclude();
  end
endmodule

bind radio_pins radio_pins_chk radio_pins_chk_inst (.sys_clk, .rstn, .sop_done, .eop_done,
  .packet_activity_indicator, .sleep_in, .sleep_active, .power_on_reset, .hop_sync_in,
  .hop_align, .mode_pin_in, .mode_pin_driven, .framing_transparent, .tdma_mode,
  .node_limit);
